// file: inc/sps_pkg.sv
// Purpose: constants, types and parameter map of the servo parameter store
// Assumes: one aligned 32-bit word per parameter, byte address = 4 * index
// Notes: slot order follows the index order of the basic-setting class
package sps_pkg;
   typedef enum logic [1:0] {SPS_ATTR_A, SPS_ATTR_B, SPS_ATTR_C, SPS_ATTR_R} sps_attr_e;

   localparam int SPS_NUM = 15;
   localparam int SPS_IW = 10;

   // register indices, byte address is four times the index
   localparam logic [9:0] SPS_IDX [SPS_NUM] = '{
      10'h000, 10'h001, 10'h002, 10'h003, 10'h004, 10'h008, 10'h009, 10'h00a,
      10'h00b, 10'h00c, 10'h00d, 10'h00e, 10'h00f, 10'h010, 10'h011};
   localparam logic [9:0] SPS_IDX_CMD = 10'h020;
   localparam logic [9:0] SPS_IDX_STAT = 10'h021;

   // slot numbers used by the decode
   localparam int SPS_S_DIR = 0;
   localparam int SPS_S_MODE = 1;
   localparam int SPS_S_TUNE = 2;
   localparam int SPS_S_STIFF = 3;
   localparam int SPS_S_INERTIA = 4;
   localparam int SPS_S_CPPR = 5;
   localparam int SPS_S_NUM = 6;
   localparam int SPS_S_DEN = 7;
   localparam int SPS_S_OPPR = 8;
   localparam int SPS_S_PLOGIC = 9;
   localparam int SPS_S_TORQUE = 10;
   localparam int SPS_S_DEV = 11;
   localparam int SPS_S_ABS = 12;
   localparam int SPS_S_REGEN = 13;
   localparam int SPS_S_METHOD = 14;

   localparam sps_attr_e SPS_ATTR [SPS_NUM] = '{
      SPS_ATTR_C, SPS_ATTR_R, SPS_ATTR_B, SPS_ATTR_B, SPS_ATTR_B, SPS_ATTR_C, SPS_ATTR_C,
      SPS_ATTR_C, SPS_ATTR_R, SPS_ATTR_R, SPS_ATTR_B, SPS_ATTR_A, SPS_ATTR_C, SPS_ATTR_C,
      SPS_ATTR_C};
   localparam logic [31:0] SPS_MIN [SPS_NUM] = '{
      32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1,
      32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
   localparam logic [31:0] SPS_MAX [SPS_NUM] = '{
      32'h1, 32'h6, 32'h6, 32'h1f, 32'h2710, 32'h40000000, 32'h40000000, 32'h40000000,
      32'h40000, 32'h3, 32'h1f4, 32'h8000000, 32'h2, 32'h3, 32'h4};
   localparam logic [31:0] SPS_RST [SPS_NUM] = '{
      32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1,
      32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

   localparam logic [31:0] SPS_MODE_RSV_LO = 32'h1;
   localparam logic [31:0] SPS_MODE_RSV_HI = 32'h5;
   localparam logic [31:0] SPS_MODE_FULL = 32'h6;
   localparam logic [31:0] SPS_TORQUE_CAP = 32'h1f4;

   // command register codes, bits [1:0]
   localparam logic [1:0] SPS_CMD_SWRST = 2'h1;
   localparam logic [1:0] SPS_CMD_VALID_C = 2'h2;

   // status register fields
   localparam int SPS_ST_IDLE = 16;
   localparam int SPS_ST_REFUSED = 17;

   localparam logic [1:0] SPS_RESP_OKAY = 2'h0;
   localparam logic [1:0] SPS_RESP_SLVERR = 2'h2;
   localparam logic [1:0] SPS_RESP_DECERR = 2'h3;

   typedef struct packed {
      logic [9:0] idx;
      logic [31:0] data;
      logic [3:0] strb;
   } sps_wreq_s;

   typedef struct packed {
      logic ccw_positive;
      logic full_closed;
      logic [2:0] control_mode;
      logic [2:0] autotune_mode;
      logic [4:0] stiffness;
      logic [15:0] inertia_ratio;
      logic [31:0] cmd_ppr;
      logic [31:0] gear_num;
      logic [31:0] gear_den;
      logic [31:0] out_ppr;
      logic [1:0] pulse_logic;
      logic [15:0] torque_limit;
      logic [31:0] deviation_limit;
      logic deviation_check_en;
      logic [1:0] abs_encoder;
      logic [1:0] regen_setup;
      logic [2:0] regen_method;
   } sps_active_s;
endpackage

// file: hdl/sps_param_cell.sv
// Purpose: one parameter with pending and active copies
// Assumes: wr_en, sw_reset and validate_c are single-cycle pulses on sys_clk; idle is a level
// Notes: attribute fixed per instance
`timescale 1ns/1ps
`default_nettype none
module sps_param_cell #(
   parameter sps_pkg::sps_attr_e ATTR = sps_pkg::SPS_ATTR_A,
   parameter logic [31:0] RST = 32'h0
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // write and activation events
   input wire logic wr_en,
   input wire logic [31:0] wr_data,
   input wire logic idle,
   input wire logic sw_reset,
   input wire logic validate_c,
   // copies
   output logic [31:0] pending,
   output logic [31:0] active
);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pending <= RST;
      end else if (wr_en) begin
         pending <= wr_data;
      end
   end

   // control-power reset restores both copies
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         active <= RST;
      end else begin
         unique case (ATTR)
            sps_pkg::SPS_ATTR_A: if (wr_en) active <= wr_data;
            sps_pkg::SPS_ATTR_B: if (idle) active <= pending;
            sps_pkg::SPS_ATTR_C: if (sw_reset || validate_c) active <= pending;
            sps_pkg::SPS_ATTR_R: if (sw_reset) active <= pending;
         endcase
      end
   end
endmodule // sps_param_cell
`default_nettype wire

// file: hdl/sps_axil_port.sv
// Purpose: AXI4-Lite slave front end of the parameter store
// Assumes: one write and one read in flight; answers come from the store
// Notes: write address and data taken in either order
`timescale 1ns/1ps
`default_nettype none
module sps_axil_port (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // write channels
   input wire logic [11:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // read channels
   input wire logic [11:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // store side
   output logic wr_fire,
   output sps_pkg::sps_wreq_s wr_req,
   input wire logic [1:0] wr_resp,
   output logic [9:0] rd_idx,
   input wire logic [31:0] rd_data,
   input wire logic [1:0] rd_resp
);
   logic aw_held;
   logic w_held;
   logic ar_held;

   assign s_awready = !aw_held && !s_bvalid;
   assign s_wready = !w_held && !s_bvalid;
   assign s_arready = !ar_held && !s_rvalid;
   assign wr_fire = aw_held && w_held;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_req <= '0;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_held <= 1'b1;
            wr_req.idx <= s_awaddr[11:2];
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (s_wvalid && s_wready) begin
            w_held <= 1'b1;
            wr_req.data <= s_wdata;
            wr_req.strb <= s_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_bvalid <= 1'b0;
         s_bresp <= sps_pkg::SPS_RESP_OKAY;
      end else if (wr_fire) begin
         s_bvalid <= 1'b1;
         s_bresp <= wr_resp;
      end else if (s_bready) begin
         s_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ar_held <= 1'b0;
         rd_idx <= '0;
         s_rvalid <= 1'b0;
         s_rdata <= '0;
         s_rresp <= sps_pkg::SPS_RESP_OKAY;
      end else begin
         if (s_arvalid && s_arready) begin
            ar_held <= 1'b1;
            rd_idx <= s_araddr[11:2];
         end else if (ar_held) begin
            ar_held <= 1'b0;
            s_rvalid <= 1'b1;
            s_rdata <= rd_data;
            s_rresp <= rd_resp;
         end else if (s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end
endmodule // sps_axil_port
`default_nettype wire

// file: hdl/sps_param_store.sv
// Purpose: basic-setting parameter store with activation by attribute
// Assumes: motor_idle_pin is asynchronous; motor_max_torque is on sys_clk
// Notes: parameter reads return the pending (last written) value
// Function
// - each parameter takes a new value only at its attribute's moment
// - always-effective parameter acts right after the write
// - reset-or-validate parameter acts on power reset, software reset or validation
// - reset-only parameter acts on power or software reset, not validation
// - read-only registers refuse normal writes
// - direction 0 makes clockwise positive, 1 counter-clockwise
// - mode 0 semi-closed, 6 full-closed, 1 to 5 reserved
// - deviation-excess limit 0 disables the deviation-excess error
// - first torque limit 0 to 500, clamped to motor maximum
// - machine stiffness accepts 0 to 31
`timescale 1ns/1ps
`default_nettype none
module sps_param_store (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // write channels
   input wire logic [11:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // read channels
   input wire logic [11:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // drive side
   input wire logic motor_idle_pin,
   input wire logic [15:0] motor_max_torque,
   output sps_pkg::sps_active_s active_out
);
   logic wr_fire;
   sps_pkg::sps_wreq_s wr_req;
   logic [1:0] wr_resp;
   logic [9:0] rd_idx;
   logic [31:0] rd_data;
   logic [1:0] rd_resp;
   logic [31:0] mask;
   logic [31:0] merged [sps_pkg::SPS_NUM];
   logic [31:0] pend [sps_pkg::SPS_NUM];
   logic [31:0] act [sps_pkg::SPS_NUM];
   logic [sps_pkg::SPS_NUM-1:0] hit;
   logic [sps_pkg::SPS_NUM-1:0] in_range;
   logic [sps_pkg::SPS_NUM-1:0] wr_en;
   logic [sps_pkg::SPS_NUM-1:0] differs;
   logic mode_reserved;
   logic slot_hit;
   logic slot_ok;
   logic cmd_hit;
   logic stat_hit;
   logic cmd_ok;
   logic sw_reset;
   logic validate_c;
   logic refused;
   logic [2:0] idle_s;
   logic idle_q;
   logic [31:0] stat_word;
   logic [31:0] torque_eff;

   sps_axil_port u_port (
      .sys_clk(sys_clk),
      .rst(rst),
      .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid),
      .s_awready(s_awready),
      .s_wdata(s_wdata),
      .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid),
      .s_wready(s_wready),
      .s_bresp(s_bresp),
      .s_bvalid(s_bvalid),
      .s_bready(s_bready),
      .s_araddr(s_araddr),
      .s_arvalid(s_arvalid),
      .s_arready(s_arready),
      .s_rdata(s_rdata),
      .s_rresp(s_rresp),
      .s_rvalid(s_rvalid),
      .s_rready(s_rready),
      .wr_fire(wr_fire),
      .wr_req(wr_req),
      .wr_resp(wr_resp),
      .rd_idx(rd_idx),
      .rd_data(rd_data),
      .rd_resp(rd_resp)
   );

   // motor idle sampled through three flops, taken when the last two agree
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         idle_s <= 3'h0;
         idle_q <= 1'b0;
      end else begin
         idle_s <= {idle_s[1:0], motor_idle_pin};
         if (idle_s[1] == idle_s[2]) begin
            idle_q <= idle_s[2];
         end
      end
   end

   assign mask = {{8{wr_req.strb[3]}}, {8{wr_req.strb[2]}}, {8{wr_req.strb[1]}},
                  {8{wr_req.strb[0]}}};

   for (genvar i = 0; i < sps_pkg::SPS_NUM; i++) begin : g_slot
      assign hit[i] = (wr_req.idx == sps_pkg::SPS_IDX[i]);
      assign merged[i] = (pend[i] & ~mask) | (wr_req.data & mask);
      // values outside the documented span are refused whole
      assign in_range[i] = (merged[i] >= sps_pkg::SPS_MIN[i]) &&
                           (merged[i] <= sps_pkg::SPS_MAX[i]);
      assign wr_en[i] = wr_fire && hit[i] && slot_ok;
      assign differs[i] = (pend[i] != act[i]);
      sps_param_cell #(
         .ATTR(sps_pkg::SPS_ATTR[i]),
         .RST(sps_pkg::SPS_RST[i])
      ) u_cell (
         .sys_clk(sys_clk),
         .rst(rst),
         .wr_en(wr_en[i]),
         .wr_data(merged[i]),
         .idle(idle_q),
         .sw_reset(sw_reset),
         .validate_c(validate_c),
         .pending(pend[i]),
         .active(act[i])
      );
   end

   assign mode_reserved = hit[sps_pkg::SPS_S_MODE] &&
                          (merged[sps_pkg::SPS_S_MODE] >= sps_pkg::SPS_MODE_RSV_LO) &&
                          (merged[sps_pkg::SPS_S_MODE] <= sps_pkg::SPS_MODE_RSV_HI);
   assign slot_hit = |hit;
   assign slot_ok = |(hit & in_range) && !mode_reserved;
   assign cmd_hit = (wr_req.idx == sps_pkg::SPS_IDX_CMD);
   assign stat_hit = (wr_req.idx == sps_pkg::SPS_IDX_STAT);
   assign cmd_ok = (wr_req.data[1:0] == sps_pkg::SPS_CMD_SWRST) ||
                   (wr_req.data[1:0] == sps_pkg::SPS_CMD_VALID_C);

   // write answer
   always_comb begin
      if (slot_hit) begin
         wr_resp = slot_ok ? sps_pkg::SPS_RESP_OKAY : sps_pkg::SPS_RESP_SLVERR;
      end else if (cmd_hit) begin
         wr_resp = cmd_ok ? sps_pkg::SPS_RESP_OKAY : sps_pkg::SPS_RESP_SLVERR;
      end else if (stat_hit) begin
         wr_resp = sps_pkg::SPS_RESP_SLVERR;
      end else begin
         wr_resp = sps_pkg::SPS_RESP_DECERR;
      end
   end

   // command pulses, one cycle after the accepted write
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sw_reset <= 1'b0;
         validate_c <= 1'b0;
      end else begin
         sw_reset <= wr_fire && cmd_hit &&
                     (wr_req.data[1:0] == sps_pkg::SPS_CMD_SWRST);
         validate_c <= wr_fire && cmd_hit &&
                       (wr_req.data[1:0] == sps_pkg::SPS_CMD_VALID_C);
      end
   end

   // flag held from the last write until the next one: refused or not
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         refused <= 1'b0;
      end else if (wr_fire) begin
         refused <= (wr_resp != sps_pkg::SPS_RESP_OKAY);
      end
   end

   always_comb begin
      stat_word = 32'h0;
      stat_word[sps_pkg::SPS_NUM-1:0] = differs;
      stat_word[sps_pkg::SPS_ST_IDLE] = idle_q;
      stat_word[sps_pkg::SPS_ST_REFUSED] = refused;
   end

   // read mux
   always_comb begin
      rd_data = 32'h0;
      rd_resp = sps_pkg::SPS_RESP_DECERR;
      for (int k = 0; k < sps_pkg::SPS_NUM; k++) begin
         if (rd_idx == sps_pkg::SPS_IDX[k]) begin
            rd_data = pend[k];
            rd_resp = sps_pkg::SPS_RESP_OKAY;
         end
      end
      if (rd_idx == sps_pkg::SPS_IDX_CMD) begin
         rd_resp = sps_pkg::SPS_RESP_OKAY;
      end
      if (rd_idx == sps_pkg::SPS_IDX_STAT) begin
         rd_data = stat_word;
         rd_resp = sps_pkg::SPS_RESP_OKAY;
      end
   end

   // usable torque bound never above the attached motor's maximum
   assign torque_eff = (act[sps_pkg::SPS_S_TORQUE] > {16'h0, motor_max_torque}) ?
                       {16'h0, motor_max_torque} : act[sps_pkg::SPS_S_TORQUE];

   // decoded active values for the control functions
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         active_out <= '0;
      end else begin
         active_out.ccw_positive <= act[sps_pkg::SPS_S_DIR][0];
         active_out.full_closed <=
            (act[sps_pkg::SPS_S_MODE] == sps_pkg::SPS_MODE_FULL);
         active_out.control_mode <= act[sps_pkg::SPS_S_MODE][2:0];
         active_out.autotune_mode <= act[sps_pkg::SPS_S_TUNE][2:0];
         active_out.stiffness <= act[sps_pkg::SPS_S_STIFF][4:0];
         active_out.inertia_ratio <= act[sps_pkg::SPS_S_INERTIA][15:0];
         active_out.cmd_ppr <= act[sps_pkg::SPS_S_CPPR];
         active_out.gear_num <= act[sps_pkg::SPS_S_NUM];
         active_out.gear_den <= act[sps_pkg::SPS_S_DEN];
         active_out.out_ppr <= act[sps_pkg::SPS_S_OPPR];
         active_out.pulse_logic <= act[sps_pkg::SPS_S_PLOGIC][1:0];
         active_out.torque_limit <= torque_eff[15:0];
         active_out.deviation_limit <= act[sps_pkg::SPS_S_DEV];
         active_out.deviation_check_en <= (act[sps_pkg::SPS_S_DEV] != 32'h0);
         active_out.abs_encoder <= act[sps_pkg::SPS_S_ABS][1:0];
         active_out.regen_setup <= act[sps_pkg::SPS_S_REGEN][1:0];
         active_out.regen_method <= act[sps_pkg::SPS_S_METHOD][2:0];
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   AST_ALWAYS_NOW: assert property (
      wr_en[sps_pkg::SPS_S_DEV] |=> act[sps_pkg::SPS_S_DEV] == $past(merged[sps_pkg::SPS_S_DEV])
   ) else $error("always-effective value not applied after write");

   AST_C_HOLD: assert property (
      (!sw_reset && !validate_c) |=> $stable(act[sps_pkg::SPS_S_DIR])
   ) else $error("reset-or-validate value changed without event");

   AST_R_HOLD: assert property (
      !sw_reset |=> $stable(act[sps_pkg::SPS_S_MODE])
   ) else $error("reset-only value changed without software reset");

   AST_B_IDLE: assert property (
      !idle_q |=> $stable(act[sps_pkg::SPS_S_STIFF])
   ) else $error("idle-only value changed while motor busy");

   AST_PEND_MOVE: assert property (
      validate_c |=> act[sps_pkg::SPS_S_DIR] == $past(pend[sps_pkg::SPS_S_DIR])
   ) else $error("pending copy not moved on validation");

   AST_RO_REFUSE: assert property (
      (wr_fire && stat_hit) |=> s_bvalid && (s_bresp == sps_pkg::SPS_RESP_SLVERR) && refused
   ) else $error("write to read-only register not refused");

   AST_DIR: assert property (
      ##1 active_out.ccw_positive == $past(act[sps_pkg::SPS_S_DIR][0])
   ) else $error("direction decode wrong");

   AST_MODE: assert property (
      ##1 active_out.full_closed == ($past(act[sps_pkg::SPS_S_MODE]) == sps_pkg::SPS_MODE_FULL)
   ) else $error("full-closed decode wrong");

   AST_MODE_RSV: assert property (
      (wr_fire && mode_reserved) |=> $stable(pend[sps_pkg::SPS_S_MODE]) && refused
   ) else $error("reserved control mode accepted");

   AST_DEV: assert property (
      ##1 active_out.deviation_check_en == ($past(act[sps_pkg::SPS_S_DEV]) != 32'h0)
   ) else $error("deviation check enable wrong");

   AST_TORQUE: assert property (
      ##1 ({16'h0, active_out.torque_limit} <= sps_pkg::SPS_TORQUE_CAP) &&
          (active_out.torque_limit <= $past(motor_max_torque))
   ) else $error("torque limit beyond bound");

   AST_STIFF: assert property (
      pend[sps_pkg::SPS_S_STIFF] <= sps_pkg::SPS_MAX[sps_pkg::SPS_S_STIFF]
   ) else $error("stiffness out of span");

   // activation moves and refusal side effects
   AST_R_MOVE: assert property (
      sw_reset |=> act[sps_pkg::SPS_S_MODE] == $past(pend[sps_pkg::SPS_S_MODE])
   ) else $error("reset-only value not moved on software reset");

   AST_C_SWRST: assert property (
      sw_reset |=> act[sps_pkg::SPS_S_DIR] == $past(pend[sps_pkg::SPS_S_DIR])
   ) else $error("reset-or-validate value not moved on software reset");

   AST_B_MOVE: assert property (
      idle_q |=> act[sps_pkg::SPS_S_STIFF] == $past(pend[sps_pkg::SPS_S_STIFF])
   ) else $error("idle-only value not applied while motor idle");

   AST_A_SAME: assert property (
      !differs[sps_pkg::SPS_S_DEV]
   ) else $error("always-effective value left pending");

   AST_CMD_EXCL: assert property (
      !(sw_reset && validate_c)
   ) else $error("software reset and validation pulsed together");

   AST_TORQUE_SPAN: assert property (
      pend[sps_pkg::SPS_S_TORQUE] <= sps_pkg::SPS_TORQUE_CAP
   ) else $error("torque limit stored beyond span");

   AST_MODE_SPAN: assert property (
      !((pend[sps_pkg::SPS_S_MODE] >= sps_pkg::SPS_MODE_RSV_LO) &&
        (pend[sps_pkg::SPS_S_MODE] <= sps_pkg::SPS_MODE_RSV_HI))
   ) else $error("reserved control mode stored");

   AST_WR_ANSWER: assert property (
      wr_fire |=> s_bvalid && (refused == (s_bresp != sps_pkg::SPS_RESP_OKAY))
   ) else $error("write answer and refused flag disagree");

   AST_REFUSED_KEEP: assert property (
      (wr_fire && (wr_resp != sps_pkg::SPS_RESP_OKAY)) |=>
         $stable(pend[sps_pkg::SPS_S_STIFF]) && $stable(pend[sps_pkg::SPS_S_TORQUE])
   ) else $error("refused write changed a pending copy");

   AST_TORQUE_CLAMP: assert property (
      ##1 (active_out.torque_limit == $past(act[sps_pkg::SPS_S_TORQUE][15:0])) ||
          (active_out.torque_limit == $past(motor_max_torque))
   ) else $error("torque limit neither stored value nor motor maximum");

   COV_VALIDATE: cover property (validate_c ##1 differs[sps_pkg::SPS_S_MODE]);
   COV_SWRST: cover property (sw_reset ##1 (differs == '0));
   COV_RO_WRITE: cover property (wr_fire && stat_hit);
   COV_NOW_WRITE: cover property (wr_en[sps_pkg::SPS_S_DEV]);
   COV_IDLE_APPLY: cover property (idle_q && differs[sps_pkg::SPS_S_STIFF]);
endmodule // sps_param_store
`default_nettype wire

// file: test/sps_host_model.sv
// Purpose: host controller writing and reading parameters over AXI4-Lite
// Assumes: one transfer at a time, signals change right after a rising edge
// Notes: waits without a bound; the bench watchdog ends a hang
`timescale 1ns/1ps
`default_nettype none
module sps_host_model (
   // clock
   input wire logic sys_clk,
   // write channels
   output logic [11:0] s_awaddr,
   output logic s_awvalid,
   input wire logic s_awready,
   output logic [31:0] s_wdata,
   output logic [3:0] s_wstrb,
   output logic s_wvalid,
   input wire logic s_wready,
   input wire logic [1:0] s_bresp,
   input wire logic s_bvalid,
   output logic s_bready,
   // read channels
   output logic [11:0] s_araddr,
   output logic s_arvalid,
   input wire logic s_arready,
   input wire logic [31:0] s_rdata,
   input wire logic [1:0] s_rresp,
   input wire logic s_rvalid,
   output logic s_rready
);
   initial begin
      {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
      {s_araddr, s_arvalid, s_rready} = '0;
   end

   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_awaddr <= a;
      s_wdata <= d;
      s_wstrb <= 4'hf;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end while (!(s_bvalid && s_bready));
      r = s_bresp;
      s_bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_arready) s_arvalid <= 1'b0;
      end while (!(s_rvalid && s_rready));
      d = s_rdata;
      r = s_rresp;
      s_rready <= 1'b0;
   endtask
endmodule // sps_host_model
`default_nettype wire

// file: test/tb_top.sv
// Purpose: self-checking bench of the parameter store
// Assumes: host model speaks AXI4-Lite, byte address is four times the index
// Notes: active values sampled on the falling edge once settled
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic sys_clk = 1'b0;
   logic rst, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rvalid, s_rready, motor_idle_pin;
   logic [11:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, d;
   logic [3:0] s_wstrb;
   logic [1:0] s_bresp, s_rresp, r;
   logic [15:0] motor_max_torque;
   sps_pkg::sps_active_s act;
   int checks = 0;
   int fail_count = 0;

   always #10 sys_clk = ~sys_clk;

   sps_host_model sps_host_model_i (.sys_clk, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
      .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
      .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
   sps_param_store sps_param_store_i (.sys_clk, .rst, .s_awaddr, .s_awvalid, .s_awready,
      .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
      .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .motor_idle_pin,
      .motor_max_torque, .active_out(act));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic put(input logic [9:0] i, input logic [31:0] v, input logic [1:0] e);
      sps_host_model_i.wr({i, 2'h0}, v, r);
      chk(32'(r), 32'(e));
   endtask

   task automatic settle;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   task automatic report_and_stop;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (8000) @(posedge sys_clk);
      fail_count++;
      report_and_stop();
   end

   initial begin
      rst = 1'b1;
      motor_idle_pin = 1'b0;
      motor_max_torque = 16'h12c;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      for (int s = 0; s < sps_pkg::SPS_NUM; s++) begin
         sps_host_model_i.rd({sps_pkg::SPS_IDX[s], 2'h0}, d, r);
         chk(d, sps_pkg::SPS_RST[s]);
         chk(32'(r), 32'(sps_pkg::SPS_RESP_OKAY));
      end
      chk(act.gear_den, sps_pkg::SPS_RST[sps_pkg::SPS_S_DEN]);
      chk(act.out_ppr, sps_pkg::SPS_RST[sps_pkg::SPS_S_OPPR]);
      // always-effective limit, zero disables the check
      put(sps_pkg::SPS_IDX[11], 32'h64, sps_pkg::SPS_RESP_OKAY);
      settle();
      chk(act.deviation_limit, 32'h64);
      chk(32'(act.deviation_check_en), 32'h1);
      put(sps_pkg::SPS_IDX[11], 32'h0, sps_pkg::SPS_RESP_OKAY);
      settle();
      chk(32'(act.deviation_check_en), 32'h0);
      // class C direction waits for validation
      put(sps_pkg::SPS_IDX[0], 32'h1, sps_pkg::SPS_RESP_OKAY);
      settle();
      chk(32'(act.ccw_positive), 32'h0);
      put(sps_pkg::SPS_IDX_CMD, 32'(sps_pkg::SPS_CMD_VALID_C), sps_pkg::SPS_RESP_OKAY);
      settle();
      chk(32'(act.ccw_positive), 32'h1);
      // class R mode ignores validation, takes software reset
      put(sps_pkg::SPS_IDX[1], 32'h3, sps_pkg::SPS_RESP_SLVERR);
      put(sps_pkg::SPS_IDX[1], 32'h6, sps_pkg::SPS_RESP_OKAY);
      put(sps_pkg::SPS_IDX_CMD, 32'(sps_pkg::SPS_CMD_VALID_C), sps_pkg::SPS_RESP_OKAY);
      settle();
      chk(32'(act.full_closed), 32'h0);
      put(sps_pkg::SPS_IDX_CMD, 32'(sps_pkg::SPS_CMD_SWRST), sps_pkg::SPS_RESP_OKAY);
      settle();
      chk(32'(act.full_closed), 32'h1);
      chk(32'(act.control_mode), 32'h6);
      put(sps_pkg::SPS_IDX_CMD, 32'h0, sps_pkg::SPS_RESP_SLVERR);
      // idle-only parameters written only while the motor stands
      @(posedge sys_clk);
      motor_idle_pin <= 1'b1;
      settle();
      put(sps_pkg::SPS_IDX[10], 32'h1f5, sps_pkg::SPS_RESP_SLVERR);
      put(sps_pkg::SPS_IDX[10], 32'h1f4, sps_pkg::SPS_RESP_OKAY);
      put(sps_pkg::SPS_IDX[3], 32'h20, sps_pkg::SPS_RESP_SLVERR);
      settle();
      chk(32'(act.stiffness), 32'h0);
      put(sps_pkg::SPS_IDX[3], 32'h1f, sps_pkg::SPS_RESP_OKAY);
      settle();
      chk(32'(act.stiffness), 32'h1f);
      chk(32'(act.torque_limit), 32'h12c);
      @(posedge sys_clk);
      motor_max_torque <= 16'h258;
      settle();
      chk(32'(act.torque_limit), 32'h1f4);
      // read-only status and unmapped place
      put(sps_pkg::SPS_IDX_STAT, 32'h0, sps_pkg::SPS_RESP_SLVERR);
      sps_host_model_i.rd({sps_pkg::SPS_IDX_STAT, 2'h0}, d, r);
      chk(32'(d[sps_pkg::SPS_ST_REFUSED]), 32'h1);
      chk(32'(r), 32'(sps_pkg::SPS_RESP_OKAY));
      sps_host_model_i.rd(12'h400, d, r);
      chk(32'(r), 32'(sps_pkg::SPS_RESP_DECERR));
      put(10'h100, 32'h0, sps_pkg::SPS_RESP_DECERR);
      // power reset in mid-run restores defaults
      @(posedge sys_clk);
      rst <= 1'b1;
      @(posedge sys_clk);
      rst <= 1'b0;
      settle();
      chk(32'(act.ccw_positive), 32'h0);
      chk(32'(act.full_closed), 32'h0);
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
